// File: logic/fviu_pkg.sv
// package: constants and carrier types of the four vector interrupt unit
package fviu_pkg;
    localparam int PC_W = 16;
    localparam int PERIPH_N = 16;
    localparam logic [PC_W-1:0] VEC_EXT_PIN = 16'h0008;
    localparam logic [PC_W-1:0] VEC_TIMER0 = 16'h0010;
    localparam logic [PC_W-1:0] VEC_CLOCK_PIN = 16'h0018;
    localparam logic [PC_W-1:0] VEC_PERIPH = 16'h0020;
    localparam int GLOBAL_DISABLE_BIT = 4;
    localparam int EXT_EDGE_SEL_BIT = 7;
    localparam int CLK_EDGE_SEL_BIT = 6;
    localparam int EXT_ENABLE_BIT = 0;
    localparam int TIMER0_ENABLE_BIT = 1;
    localparam int CLK_ENABLE_BIT = 2;
    localparam int PERIPH_ENABLE_BIT = 3;
    localparam int EXT_FLAG_BIT = 4;
    localparam int TIMER0_FLAG_BIT = 5;
    localparam int CLK_FLAG_BIT = 6;
    localparam int PERIPH_PEND_BIT = 7;
    localparam logic RST_GLOBAL_DISABLE = 1'b1;
    localparam logic [7:0] RST_INT_STATUS = 8'h00;
    localparam logic [7:0] RST_TIMER0_STATUS = 8'h00;

    typedef enum logic [1:0] {SRC_EXT, SRC_TIMER0, SRC_CLOCK, SRC_PERIPH} fviu_src_t;

    // software access to the three status bytes seen by this block
    typedef struct packed {
        logic writeEn;
        logic [7:0] data;
    } fviu_wr_t;

    // jump request toward the core program counter and stack
    typedef struct packed {
        logic take;
        logic [PC_W-1:0] vector;
    } fviu_jump_t;
endpackage : fviu_pkg

// File: logic/fviu_unit.sv
// four vector interrupt unit: sources, flags, priority and vectoring
`timescale 1ns/10ps
`default_nettype none
module fviu_unit
    import fviu_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic extIntPin,
    input wire logic timerClockPin,
    input wire logic timer0Overflow,
    input wire logic [PERIPH_N-1:0] periphFlagRegs,
    input wire logic [PERIPH_N-1:0] periphEnableRegs,
    input wire logic [PERIPH_N-1:0] periphWakeCapable,
    input wire fviu_wr_t cpuStatusWr,
    input wire fviu_wr_t timer0StatusWr,
    input wire fviu_wr_t intStatusWr,
    input wire logic returnFromIntInstr,
    input wire logic [PC_W-1:0] returnPc,
    output logic globalIntDisable,
    output logic [7:0] intStatusReg,
    output logic [7:0] timer0StatusReg,
    output fviu_jump_t jumpReq,
    output logic [PC_W-1:0] pushAddr,
    output logic pushStack,
    output logic popStack,
    output logic wakeReq
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [1:0] extSync_q;
    logic [1:0] clkSync_q;
    logic extLast_q;
    logic clkLast_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extSync_q <= 2'h0;
            clkSync_q <= 2'h0;
            extLast_q <= 1'b0;
            clkLast_q <= 1'b0;
        end
        else
        begin
            extSync_q <= {extSync_q[0], extIntPin};
            clkSync_q <= {clkSync_q[0], timerClockPin};
            extLast_q <= extSync_q[1];
            clkLast_q <= clkSync_q[1];
        end
    end

    logic extEdge;
    logic clkEdge;
    assign extEdge = timer0StatusReg[EXT_EDGE_SEL_BIT] ? (extSync_q[1] & ~extLast_q)
                                                       : (~extSync_q[1] & extLast_q);
    assign clkEdge = timer0StatusReg[CLK_EDGE_SEL_BIT] ? (clkSync_q[1] & ~clkLast_q)
                                                       : (~clkSync_q[1] & clkLast_q);

    ////////////////////////////////////////////////////////////////////////
    // timer0 status: edge selects only, other bits belong to the timer
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            timer0StatusReg <= RST_TIMER0_STATUS;
        else if (timer0StatusWr.writeEn)
            timer0StatusReg <= timer0StatusWr.data;
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral pending, read only
    logic periphPending;
    // or of flag and enable pairs
    assign periphPending = |(periphFlagRegs & periphEnableRegs);

    ////////////////////////////////////////////////////////////////////////
    // interrupt status: flags and enables; event set wins over software clear
    logic [7:0] intStatus_d;
    always_comb
    begin
        intStatus_d = intStatusReg;
        if (intStatusWr.writeEn)
            intStatus_d = intStatusWr.data;
        if (extEdge)
            intStatus_d[EXT_FLAG_BIT] = 1'b1;
        if (timer0Overflow)
            intStatus_d[TIMER0_FLAG_BIT] = 1'b1;
        if (clkEdge)
            intStatus_d[CLK_FLAG_BIT] = 1'b1;
        intStatus_d[PERIPH_PEND_BIT] = periphPending;
    end

    // ext, timer0 and clock pin flags held until software clears them; the pending bit follows periphPending
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            intStatusReg <= RST_INT_STATUS;
        else
            intStatusReg <= intStatus_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // request qualification and priority
    logic [3:0] srcReq;
    assign srcReq[0] = intStatusReg[EXT_FLAG_BIT] & intStatusReg[EXT_ENABLE_BIT];
    assign srcReq[1] = intStatusReg[TIMER0_FLAG_BIT] & intStatusReg[TIMER0_ENABLE_BIT];
    assign srcReq[2] = intStatusReg[CLK_FLAG_BIT] & intStatusReg[CLK_ENABLE_BIT];
    assign srcReq[3] = periphPending & intStatusReg[PERIPH_ENABLE_BIT];

    logic accept;
    assign accept = (|srcReq) & ~globalIntDisable & ~returnFromIntInstr;

    fviu_src_t winner;
    logic [PC_W-1:0] winVector;
    always_comb
    begin
        if (srcReq[0])
            winner = SRC_EXT;
        else if (srcReq[1])
            winner = SRC_TIMER0;
        else if (srcReq[2])
            winner = SRC_CLOCK;
        else
            winner = SRC_PERIPH;
    end

    always_comb
    begin
        unique case (winner)
            SRC_EXT: winVector = VEC_EXT_PIN;
            SRC_TIMER0: winVector = VEC_TIMER0;
            SRC_CLOCK: winVector = VEC_CLOCK_PIN;
            SRC_PERIPH: winVector = VEC_PERIPH;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // global disable: reset, accept, return and software writes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            globalIntDisable <= RST_GLOBAL_DISABLE;
        else if (accept)
            globalIntDisable <= 1'b1;
        else if (returnFromIntInstr)
            globalIntDisable <= 1'b0;
        else if (cpuStatusWr.writeEn)
            globalIntDisable <= cpuStatusWr.data[GLOBAL_DISABLE_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // core side strobes; only the return pc is saved, nothing else
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            jumpReq <= '0;
            pushAddr <= '0;
            pushStack <= 1'b0;
            popStack <= 1'b0;
        end
        else
        begin
            jumpReq.take <= accept;
            jumpReq.vector <= accept ? winVector : jumpReq.vector;
            pushStack <= accept;
            pushAddr <= accept ? returnPc : pushAddr;
            popStack <= returnFromIntInstr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake from sleep ignores global disable so a disabled core still wakes
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wakeReq <= 1'b0;
        else
            wakeReq <= srcReq[0] | srcReq[2]
                       | (|(periphFlagRegs & periphEnableRegs & periphWakeCapable)
                          & intStatusReg[PERIPH_ENABLE_BIT]);
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    reset_disable_a:
        assert property (@(posedge clock) $rose(rst_n) |-> globalIntDisable)
        else $error("global disable not set after reset");
    blocked_global_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            $past(globalIntDisable) && !$past(rst_n) == 1'b0 |-> !jumpReq.take)
        else $error("interrupt taken while disabled");
    entry_sets_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            jumpReq.take |-> globalIntDisable && pushStack)
        else $error("entry without disable or push");
    return_clear_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            returnFromIntInstr |=> !globalIntDisable && popStack)
        else $error("return did not re-enable");
    ext_vector_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            accept && srcReq[0] |=> jumpReq.vector == VEC_EXT_PIN)
        else $error("wrong external vector");
    periph_vector_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            accept && srcReq == 4'h8 |=> jumpReq.vector == VEC_PERIPH)
        else $error("wrong peripheral vector");
    clock_prio_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            accept && srcReq[2:0] == 3'h4 |=> jumpReq.vector == VEC_CLOCK_PIN)
        else $error("priority order broken");
    flag_sticky_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            extEdge |=> intStatusReg[EXT_FLAG_BIT])
        else $error("external flag not set");
    periph_mask_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            !intStatusReg[PERIPH_ENABLE_BIT] |-> !srcReq[3])
        else $error("peripheral not masked");
    pend_or_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            ##1 intStatusReg[PERIPH_PEND_BIT] == $past(periphPending))
        else $error("pending bit mismatch");
    timer_vector_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            accept && srcReq[1:0] == 2'h2 |=> jumpReq.vector == VEC_TIMER0)
        else $error("wrong timer vector");
    take_pulse_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            jumpReq.take |=> !jumpReq.take)
        else $error("jump request longer than one cycle");
    push_addr_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            accept |=> pushAddr == $past(returnPc))
        else $error("pushed address is not the return pc");
    clk_flag_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            clkEdge |=> intStatusReg[CLK_FLAG_BIT])
        else $error("clock pin flag not set");
    ext_mask_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            !intStatusReg[EXT_ENABLE_BIT] |-> !srcReq[0])
        else $error("external request not masked");
    ext_wake_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            srcReq[0] |=> wakeReq)
        else $error("external request did not wake");
    timer_flag_a:
        assert property (@(posedge clock) disable iff (!rst_n)
            timer0Overflow |=> intStatusReg[TIMER0_FLAG_BIT])
        else $error("timer flag not set");

    ext_take_c: cover property (@(posedge clock) accept && winner == SRC_EXT);
    periph_take_c: cover property (@(posedge clock) accept && winner == SRC_PERIPH);
    return_c: cover property (@(posedge clock) jumpReq.take ##[1:20] returnFromIntInstr);
    wake_c: cover property (@(posedge clock) wakeReq && globalIntDisable);
    clock_wake_c: cover property (@(posedge clock) wakeReq && intStatusReg[CLK_FLAG_BIT]);

endmodule : fviu_unit
`default_nettype wire

// File: verif/fviu_core_model.sv
// core model: program counter and return stack facing the interrupt unit
`timescale 1ns/10ps
`default_nettype none
module fviu_core_model
    import fviu_pkg::*;
#(
    parameter int DEPTH = 16
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pushStack,
    input wire logic popStack,
    input wire logic [PC_W-1:0] pushAddr,
    output logic [PC_W-1:0] returnPc,
    output logic [PC_W-1:0] stackTop,
    output logic [4:0] stackDepth
);
    logic [PC_W-1:0] stackMem [DEPTH];

    ////////////////////////////////////////////////////////////////////////////////
    // pc moves every cycle so a stale push address cannot match by luck
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            returnPc <= 16'h0100;
        else
            returnPc <= returnPc + 16'h0003;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // only pc stacked
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            stackDepth <= 5'h00;
        else if (pushStack && stackDepth < 5'(DEPTH))
        begin
            stackMem[stackDepth[3:0]] <= pushAddr;
            stackDepth <= stackDepth + 5'h01;
        end
        else if (popStack && stackDepth != 5'h00)
            stackDepth <= stackDepth - 5'h01;
    end

    // empty stack shows a pattern unlike any pushed value
    assign stackTop = (stackDepth != 5'h00) ? stackMem[stackDepth[3:0] - 4'h1] : 16'hdead;
endmodule : fviu_core_model
`default_nettype wire

// File: verif/tb.sv
// testbench of the four vector interrupt unit
`timescale 1ns/10ps
`default_nettype none
module tb
    import fviu_pkg::*;
;
    logic clock = 1'b0, rst_n = 1'b0, extIntPin = 1'b0, timerClockPin = 1'b0;
    logic timer0Overflow = 1'b0, returnFromIntInstr = 1'b0;
    logic [PERIPH_N-1:0] periphFlagRegs = '0, periphEnableRegs = '0, periphWakeCapable = '0;
    fviu_wr_t cpuWr = '0, t0Wr = '0, intWr = '0;
    logic globalIntDisable, pushStack, popStack, wakeReq;
    logic [7:0] intStatusReg;
    fviu_jump_t jumpReq;
    logic [PC_W-1:0] pushAddr, returnPc, stackTop, pcLast;
    logic [4:0] stackDepth;
    logic [31:0] rnd = 32'h3232b792;
    logic [7:0] st, t0Status;
    logic [15:0] pf, pe, pw;
    logic [3:0] k;
    int err_count = 0, total_checks = 0, takeCount = 0;
    logic [15:0] vecs [4] = '{VEC_EXT_PIN, VEC_TIMER0, VEC_CLOCK_PIN, VEC_PERIPH};
    logic [7:0] fl [4] = '{8'h10, 8'h20, 8'h40, 8'h00};

    fviu_unit fviu_unit_i (.clock(clock), .rst_n(rst_n), .extIntPin(extIntPin),
        .timerClockPin(timerClockPin), .timer0Overflow(timer0Overflow),
        .periphFlagRegs(periphFlagRegs), .periphEnableRegs(periphEnableRegs),
        .periphWakeCapable(periphWakeCapable), .cpuStatusWr(cpuWr), .timer0StatusWr(t0Wr),
        .intStatusWr(intWr), .returnFromIntInstr(returnFromIntInstr), .returnPc(returnPc),
        .globalIntDisable(globalIntDisable), .intStatusReg(intStatusReg),
        .timer0StatusReg(t0Status), .jumpReq(jumpReq), .pushAddr(pushAddr),
        .pushStack(pushStack), .popStack(popStack), .wakeReq(wakeReq));
    fviu_core_model fviu_core_model_i (.clock(clock), .rst_n(rst_n), .pushStack(pushStack),
        .popStack(popStack), .pushAddr(pushAddr), .returnPc(returnPc),
        .stackTop(stackTop), .stackDepth(stackDepth));

    always #25 clock = ~clock;
    always @(posedge clock)
    begin
        pcLast <= returnPc;
        if (jumpReq.take === 1'b1)
            takeCount <= takeCount + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // wake from a peripheral needs flag, enable and wake capability together
    function automatic logic expWake(input logic [15:0] f, e, w);
        return |(f & e & w);
    endfunction : expWake
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // sel 0 cpu status, 1 timer0 status, 2 int status
    task automatic wr(input int sel, input logic [7:0] d);
        @(posedge clock);
        if (sel == 0) cpuWr <= {1'b1, d};
        else if (sel == 1) t0Wr <= {1'b1, d};
        else intWr <= {1'b1, d};
        @(posedge clock);
        cpuWr.writeEn <= 1'b0;
        t0Wr.writeEn <= 1'b0;
        intWr.writeEn <= 1'b0;
        #1;
    endtask : wr
    task automatic waitTake;
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            #1;
            n++;
        end while (jumpReq.take !== 1'b1 && n < 20);
        chk(16'(jumpReq.take), 16'h1);
    endtask : waitTake
    task automatic ret;
        @(posedge clock);
        returnFromIntInstr <= 1'b1;
        @(posedge clock);
        returnFromIntInstr <= 1'b0;
        #1;
        chk(16'(popStack), 16'h1);
        chk(16'(globalIntDisable), 16'h0);
    endtask : ret

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge clock);
        err_count++;
        finish_test();
    end

    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rnd = lfsr(rnd);
        k = rnd[3:0];
        periphWakeCapable <= rnd[31:16];
        cyc(1);
        chk(16'(globalIntDisable), 16'h1);
        chk(16'(intStatusReg), 16'h0);
        @(posedge clock);
        timer0Overflow <= 1'b1;
        @(posedge clock);
        timer0Overflow <= 1'b0;
        cyc(2);
        chk(16'(intStatusReg[5]), 16'h1);
        wr(1, 8'hc0);
        chk(16'(t0Status), 16'h00c0);
        extIntPin <= 1'b1;
        cyc(6);
        chk(16'(intStatusReg[4]), 16'h1);
        timerClockPin <= 1'b1;
        cyc(6);
        chk(16'(intStatusReg[6]), 16'h1);
        periphFlagRegs <= 16'h1 << k;
        periphEnableRegs <= ~(16'h1 << k);
        cyc(3);
        chk(16'(intStatusReg[7]), 16'h0);
        periphEnableRegs <= '1;
        cyc(3);
        chk(16'(intStatusReg[7]), 16'h1);
        chk(16'(takeCount), 16'h0);
        st = 8'h7f;
        wr(2, st);
        cyc(3);
        chk(16'(takeCount), 16'h0);
        wr(0, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            waitTake();
            chk(jumpReq.vector, vecs[i]);
            chk(pushAddr, pcLast);
            chk(16'(pushStack), 16'h1);
            chk(16'(globalIntDisable), 16'h1);
            cyc(1);
            chk(16'(jumpReq.take), 16'h0);
            chk(16'(pushStack), 16'h0);
            chk(stackTop, pcLast - 16'h0003);
            chk(16'(stackDepth), 16'h1);
            st = st & ~fl[i];
            // serviced flag cleared before returning
            wr(2, st);
            if (i == 3) periphFlagRegs <= '0;
            ret();
        end
        cyc(4);
        chk(16'(takeCount), 16'h4);
        // disable first, then drop the peripheral enable
        wr(0, 8'h10);
        wr(2, 8'h07);
        wr(0, 8'h00);
        periphFlagRegs <= 16'h1 << k;
        cyc(5);
        chk(16'(takeCount), 16'h4);
        periphEnableRegs <= ~(16'h1 << k);
        wr(2, 8'h0f);
        cyc(5);
        chk(16'(takeCount), 16'h4);
        wr(0, 8'h10);
        wr(1, 8'h00);
        periphFlagRegs <= '0;
        extIntPin <= 1'b0;
        cyc(6);
        chk(16'(intStatusReg[4]), 16'h1);
        wr(2, 8'h11);
        cyc(2);
        chk(16'(wakeReq), 16'h1);
        chk(16'(takeCount), 16'h4);
        // ext enable dropped while globally disabled
        wr(2, 8'h10);
        wr(0, 8'h00);
        cyc(3);
        chk(16'(takeCount), 16'h4);
        chk(16'(intStatusReg[4]), 16'h1);
        wr(0, 8'h10);
        wr(2, 8'h08);
        // random peripheral mixes; the first has no wake capable source
        for (int j = 0; j < 6; j++)
        begin
            rnd = lfsr(rnd);
            pf = rnd[15:0];
            pe = rnd[31:16];
            rnd = lfsr(rnd);
            pw = (j == 0) ? 16'h0000 : rnd[15:0];
            periphFlagRegs <= pf;
            periphEnableRegs <= pe;
            periphWakeCapable <= pw;
            cyc(2);
            chk(16'(wakeReq), 16'(expWake(pf, pe, pw)));
            chk(16'(intStatusReg[7]), 16'(|(pf & pe)));
        end
        periphFlagRegs <= '0;
        timerClockPin <= 1'b0;
        cyc(6);
        chk(16'(intStatusReg[6]), 16'h1);
        wr(2, 8'h44);
        cyc(2);
        chk(16'(wakeReq), 16'h1);
        chk(16'(takeCount), 16'h4);
        // clearing write and overflow in one cycle: the event wins
        @(posedge clock);
        intWr <= {1'b1, 8'h44};
        timer0Overflow <= 1'b1;
        @(posedge clock);
        intWr.writeEn <= 1'b0;
        timer0Overflow <= 1'b0;
        #1;
        chk(16'(intStatusReg[5]), 16'h1);
        // reset in mid run
        @(posedge clock);
        rst_n <= 1'b0;
        cyc(2);
        chk(16'(globalIntDisable), 16'h1);
        chk(16'(intStatusReg), 16'h0);
        chk(16'(wakeReq), 16'h0);
        @(posedge clock);
        rst_n <= 1'b1;
        cyc(2);
        chk(16'(globalIntDisable), 16'h1);
        chk(16'(takeCount), 16'h4);
        finish_test();
    end
endmodule : tb
`default_nettype wire
